// File: adcs_regs.svh
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// Register byte offsets on the plain register port
`define ADCS_REG_CTRL 4'h0
`define ADCS_REG_STATUS 4'h4
`define ADCS_REG_RESULT 4'h8

// Field positions
`define ADCS_CTRL_SYNC 0
`define ADCS_STAT_READY 0
`define ADCS_STAT_MASTER 1
`define ADCS_STAT_VALID 2
`define ADCS_STAT_BUSY 3
`define ADCS_INSTR_READ 7
`define ADCS_CMD_SYNC 0

// Widths and reset values
`define ADCS_RESULT_W 24
`define ADCS_RESULT_RST 24'h000000
`define ADCS_SETTLE_PLAIN 3'h4
`define ADCS_SETTLE_SYNC 3'h3

// Timing, clock period 4 ns
`define ADCS_CLK_NS 4
`define ADCS_TURN_CYC 7
`define ADCS_T_DATA_NS 64
`define ADCS_SLAVE_TDATA_CYC (`ADCS_T_DATA_NS / `ADCS_CLK_NS)
`define ADCS_MASTER_TDATA_CYC 4
`define ADCS_TIMEOUT_BITS 8
`define ADCS_CONV_CYC 1024
`define ADCS_RST_HIGH_NS 2048
`define ADCS_RST_HIGH_CYC ((`ADCS_RST_HIGH_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)

`endif

// File: adcs_pkg.sv
package adcs_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_instr,
		st_turn,
		st_send,
		st_recv
	} adcs_state_t;
endpackage

// File: adcs_sync.sv
`timescale 1ns/1ps
module adcs_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					stage1[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					stage1[i] <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule

// File: adcs_timer.sv
`timescale 1ns/1ps
module adcs_timer (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic run_in,
	input wire logic clear_in,
	input wire logic [7:0] limit_in,
	// Result
	output logic expire_out
);
	logic [7:0] count;

	// Idle count on the master clock, cleared by every serial edge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= 8'h00;
			expire_out <= 1'b0;
		end else if (!run_in || clear_in) begin
			count <= 8'h00;
			expire_out <= 1'b0;
		end else begin
			count <= count + 8'h01;
			expire_out <= (count == limit_in - 8'h01);
		end
	end
endmodule

// File: adcs_top.sv
`timescale 1ns/1ps
`include "adcs_regs.svh"
// Function
// - Mode-select low makes the serial port a clock-receiving slave.
// - Slave mode accepts many instructions per period, host paces clock.
// - Read turnaround starts at instruction's last falling edge, done 6-8 cycles.
// - Unaccessed period: result overwritten, ready pin high then low around it.
// - Sync pin or command bit zeroes modulator count, discards gathered data.
// - Sync keeps the two stored outputs and uses both next result.
// - Channel change plus sync: valid after three more cycles; else four.
// - The cycle holding a sync is lengthened depending on its timing.
// - Slave only: serial clock duty pattern performs a full reset.
// - Master mode offers no reset through the serial pins.
// - Master starts traffic only when ready, one instruction per period.
// - A readable ready status bit lets a fast poller see new data.
// - Stall over eight bit periods resets only the serial interface.
// - Data output pins float except while shifting data out.
// - Low sync pulse restarts counts together across converters.
// - Asynchronous sync is sampled with one master clock of uncertainty.
// - Mode-select high gives master mode, serial clock at a quarter rate.
// - Read in progress blocks the update; old result kept, new dropped.
module adcs_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Converter pins
	input wire logic mode_sel_in,
	input wire logic conversion_sync_n_in,
	output logic result_ready_n_out,
	// Serial clock pin
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n_out,
	// Serial data pins
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n_out,
	output logic serial_result_out,
	output logic serial_result_oe_n_out,
	// Modulator side
	input wire logic mod_bit_in,
	input wire logic chan_change_in,
	output logic result_valid_out,
	// Register port
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rd_data_out
);
	////////////////////////////////////////////////////////////////////////
	logic rst_meta, rst_n;
	logic [3:0] pins_s;
	logic mode_s, sync_n_s, sclk_s, sdio_s;
	logic sclk_d, sync_n_d, master;
	logic s_rise, s_fall, m_rise, m_fall, rise, fall, m_active;
	logic sync_fall, bus_sync, ser_sync, sync_evt, soft_rst, rst_armed;
	logic tmo, served, reading, ready_n, valid, sclk_q, sclk_oe_n, oe_n;
	logic sd_q;
	logic [1:0] div;
	logic [9:0] hi_cnt;
	logic [4:0] bit_cnt;
	logic [2:0] turn_cnt, settle;
	logic [7:0] instr, wbyte, limit;
	logic [9:0] conv_cnt;
	logic [`ADCS_RESULT_W-1:0] acc, prev1, prev2, result_register, shreg;
	adcs_pkg::adcs_state_t state;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	adcs_sync #(.WIDTH(4)) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.async_in({mode_sel_in, conversion_sync_n_in, sclk_in, sdio_in}),
		.sync_out(pins_s)
	);
	assign {mode_s, sync_n_s, sclk_s, sdio_s} = pins_s;
	assign master = mode_s;
	assign s_rise = !master && sclk_s && !sclk_d;
	assign s_fall = !master && !sclk_s && sclk_d;
	// Edge of the synchronised level; one clock of jitter between parts
	assign sync_fall = sync_n_d && !sync_n_s;
	assign sync_evt = sync_fall || bus_sync || ser_sync;
	assign m_active = master && (state == adcs_pkg::st_instr ||
		state == adcs_pkg::st_send || state == adcs_pkg::st_recv);
	assign m_rise = m_active && (div == 2'h1);
	assign m_fall = m_active && (div == 2'h3);
	assign rise = master ? m_rise : s_rise;
	assign fall = master ? m_fall : s_fall;
	assign reading = (state == adcs_pkg::st_turn) ||
		(state == adcs_pkg::st_send);
	assign limit = master ? 8'(`ADCS_TIMEOUT_BITS * `ADCS_MASTER_TDATA_CYC)
		: 8'(`ADCS_TIMEOUT_BITS * `ADCS_SLAVE_TDATA_CYC);

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			// Matches the synchroniser's reset level: no false sync
			sync_n_d <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
			sync_n_d <= sync_n_s;
		end
	end

	adcs_timer u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.run_in(state != adcs_pkg::st_idle && state != adcs_pkg::st_turn),
		.clear_in(rise || fall),
		.limit_in(limit),
		.expire_out(tmo)
	);

	////////////////////////////////////////////////////////////////////////
	// Master serial clock: four master clocks per bit
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			div <= 2'h0;
			sclk_q <= 1'b0;
			sclk_oe_n <= 1'b1;
		end else begin
			sclk_oe_n <= !master;
			if (m_active) begin
				div <= div + 2'h1;
				sclk_q <= (div == 2'h1) || (div == 2'h2);
			end else begin
				div <= 2'h0;
				sclk_q <= 1'b0;
			end
		end
	end

	// Long serial clock high then low in slave mode resets the device
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt <= 10'h000;
			rst_armed <= 1'b0;
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= rst_armed && s_fall;
			if (master || !sclk_s) begin
				hi_cnt <= 10'h000;
			end else if (hi_cnt != 10'(`ADCS_RST_HIGH_CYC)) begin
				hi_cnt <= hi_cnt + 10'h001;
			end
			if (master) begin
				rst_armed <= 1'b0;
			end else if (sclk_s && hi_cnt == 10'(`ADCS_RST_HIGH_CYC)) begin
				rst_armed <= 1'b1;
			end else if (s_fall) begin
				rst_armed <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial instruction engine
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= adcs_pkg::st_idle;
			bit_cnt <= 5'h00;
			turn_cnt <= 3'h0;
			instr <= 8'h00;
			wbyte <= 8'h00;
			shreg <= `ADCS_RESULT_RST;
			sd_q <= 1'b0;
			oe_n <= 1'b1;
			ser_sync <= 1'b0;
		end else if (soft_rst || tmo) begin
			state <= adcs_pkg::st_idle;
			oe_n <= 1'b1;
			ser_sync <= 1'b0;
		end else begin
			ser_sync <= 1'b0;
			case (state)
			adcs_pkg::st_idle: begin
				bit_cnt <= 5'h00;
				if (master && !ready_n && !served) begin
					state <= adcs_pkg::st_instr;
				end else if (s_rise) begin
					instr <= {7'h00, sdio_s};
					bit_cnt <= 5'h01;
					state <= adcs_pkg::st_instr;
				end
			end
			adcs_pkg::st_instr: begin
				if (rise && bit_cnt < 5'h08) begin
					instr <= {instr[6:0], sdio_s};
					bit_cnt <= bit_cnt + 5'h01;
				end else if (fall && bit_cnt == 5'h08) begin
					bit_cnt <= 5'h00;
					turn_cnt <= 3'h0;
					state <= instr[`ADCS_INSTR_READ] ? adcs_pkg::st_turn
						: adcs_pkg::st_recv;
				end
			end
			adcs_pkg::st_turn: begin
				turn_cnt <= turn_cnt + 3'h1;
				if (turn_cnt == 3'(`ADCS_TURN_CYC - 1)) begin
					state <= adcs_pkg::st_send;
					oe_n <= 1'b0;
					shreg <= result_register;
					sd_q <= result_register[`ADCS_RESULT_W-1];
				end
			end
			adcs_pkg::st_send: begin
				if (fall) begin
					if (bit_cnt == 5'(`ADCS_RESULT_W - 1)) begin
						state <= adcs_pkg::st_idle;
						oe_n <= 1'b1;
					end else begin
						shreg <= {shreg[`ADCS_RESULT_W-2:0], 1'b0};
						sd_q <= shreg[`ADCS_RESULT_W-2];
						bit_cnt <= bit_cnt + 5'h01;
					end
				end
			end
			adcs_pkg::st_recv: begin
				if (rise && bit_cnt < 5'h08) begin
					wbyte <= {wbyte[6:0], sdio_s};
					bit_cnt <= bit_cnt + 5'h01;
				end else if (bit_cnt == 5'h08) begin
					ser_sync <= wbyte[`ADCS_CMD_SYNC];
					state <= adcs_pkg::st_idle;
				end
			end
			default: state <= adcs_pkg::st_idle;
			endcase
		end
	end

	// One instruction per ready period in master mode
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			served <= 1'b0;
		end else if (soft_rst || conv_cnt == 10'(`ADCS_CONV_CYC - 1)) begin
			served <= 1'b0;
		end else if (master && state == adcs_pkg::st_idle && !ready_n) begin
			served <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion timing and result update; mode changes leave it alone
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt <= 10'h000;
			acc <= `ADCS_RESULT_RST;
			prev1 <= `ADCS_RESULT_RST;
			prev2 <= `ADCS_RESULT_RST;
			result_register <= `ADCS_RESULT_RST;
			ready_n <= 1'b1;
		end else if (soft_rst) begin
			conv_cnt <= 10'h000;
			acc <= `ADCS_RESULT_RST;
			prev1 <= `ADCS_RESULT_RST;
			prev2 <= `ADCS_RESULT_RST;
			result_register <= `ADCS_RESULT_RST;
			ready_n <= 1'b1;
		end else if (sync_evt) begin
			conv_cnt <= 10'h000;
			acc <= `ADCS_RESULT_RST;
		end else if (conv_cnt == 10'(`ADCS_CONV_CYC - 1)) begin
			conv_cnt <= 10'h000;
			acc <= `ADCS_RESULT_RST;
			prev1 <= acc;
			prev2 <= prev1;
			ready_n <= 1'b0;
			if (!reading) begin
				result_register <= acc + prev1 + prev2;
			end
		end else begin
			conv_cnt <= conv_cnt + 10'h001;
			acc <= acc + `ADCS_RESULT_W'(mod_bit_in);
			if (conv_cnt == 10'(`ADCS_CONV_CYC - 2)) begin
				ready_n <= 1'b1;
			end
		end
	end

	// Settling of data after a channel change
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			settle <= 3'h0;
			valid <= 1'b1;
		end else begin
			valid <= (settle == 3'h0);
			if (soft_rst) begin
				settle <= 3'h0;
			end else if (chan_change_in) begin
				settle <= `ADCS_SETTLE_PLAIN;
			end else if (sync_evt && settle != 3'h0) begin
				settle <= `ADCS_SETTLE_SYNC;
			end else if (conv_cnt == 10'(`ADCS_CONV_CYC - 1) &&
				settle != 3'h0) begin
				settle <= settle - 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bus_sync <= 1'b0;
			rd_data_out <= 32'h00000000;
		end else begin
			bus_sync <= wr_in && hit(addr_in, `ADCS_REG_CTRL) &&
				wr_data_in[`ADCS_CTRL_SYNC];
			rd_data_out <= 32'h00000000;
			if (rd_in && hit(addr_in, `ADCS_REG_STATUS)) begin
				rd_data_out[`ADCS_STAT_READY] <= !ready_n;
				rd_data_out[`ADCS_STAT_MASTER] <= master;
				rd_data_out[`ADCS_STAT_VALID] <= valid;
				rd_data_out[`ADCS_STAT_BUSY] <= state != adcs_pkg::st_idle;
			end else if (rd_in && hit(addr_in, `ADCS_REG_RESULT)) begin
				rd_data_out <= {8'h00, result_register};
			end
		end
	end

	assign result_ready_n_out = ready_n;
	assign sclk_out = sclk_q;
	assign sclk_oe_n_out = sclk_oe_n;
	assign sdio_out = sd_q;
	assign sdio_oe_n_out = oe_n;
	assign serial_result_out = sd_q;
	assign serial_result_oe_n_out = oe_n;
	assign result_valid_out = valid;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	a_slave_clock_in: assert property (
		!master |-> ##1 sclk_oe_n_out)
		else $error("sclk driven in slave mode");
	a_master_sclk_rate: assert property (
		$rose(sclk_out) |-> sclk_out ##1 sclk_out ##1 !sclk_out ##1 !sclk_out)
		else $error("master sclk not a quarter rate");
	a_turn_delay: assert property (
		state == adcs_pkg::st_turn && $past(state) != adcs_pkg::st_turn
		|-> sdio_oe_n_out [*6] ##[1:2] !sdio_oe_n_out)
		else $error("turnaround outside six to eight cycles");
	a_ready_around_update: assert property (
		conv_cnt == 10'(`ADCS_CONV_CYC - 1) && !sync_evt && !soft_rst
		|-> result_ready_n_out ##1 !result_ready_n_out)
		else $error("ready pin not high before update");
	a_sync_clears_count: assert property (
		sync_evt && !soft_rst |=> conv_cnt == 10'h000 && acc == 24'h000000)
		else $error("sync did not clear modulator count");
	a_sync_keeps_history: assert property (
		sync_evt && !soft_rst |=> prev1 == $past(prev1) &&
		prev2 == $past(prev2))
		else $error("sync lost stored outputs");
	a_settle_after_sync: assert property (
		sync_evt && !chan_change_in && !soft_rst && settle != 3'h0
		|=> settle == 3'h3)
		else $error("settle count wrong after sync");
	a_one_per_period: assert property (
		master && served && state == adcs_pkg::st_idle && !soft_rst &&
		conv_cnt != 10'(`ADCS_CONV_CYC - 1) |=> state == adcs_pkg::st_idle)
		else $error("second master instruction in a period");
	a_status_ready_bit: assert property (
		rd_in && addr_in == `ADCS_REG_STATUS
		|=> rd_data_out[0] == !$past(result_ready_n_out))
		else $error("status ready bit mismatch");
	a_timeout_idle: assert property (
		tmo |=> state == adcs_pkg::st_idle && sdio_oe_n_out)
		else $error("timeout did not reset serial port");
	a_output_float: assert property (
		!sdio_oe_n_out |-> state == adcs_pkg::st_send ||
		$past(state) == adcs_pkg::st_send)
		else $error("data pin driven outside shifting");
	a_read_blocks_update: assert property (
		conv_cnt == 10'(`ADCS_CONV_CYC - 1) && reading && !sync_evt
		|=> result_register == $past(result_register))
		else $error("update not blocked during read");

	c_slave_read: cover property (
		!master && state == adcs_pkg::st_send ##1 state == adcs_pkg::st_idle);
	c_master_read: cover property (
		master && state == adcs_pkg::st_send);
	c_sync_pulse: cover property (sync_fall);
	c_sclk_reset: cover property (soft_rst);
endmodule

// File: adcs_host_model.sv
`timescale 1ns/1ps
module adcs_host_model (
	// Clock
	input wire logic clk_in,
	// Serial pins as the host sees them
	input wire logic sdio_in,
	input wire logic sdio_oe_n_in,
	input wire logic serial_result_out_in,
	output logic sclk_out,
	output logic sdio_out,
	// Read results
	output logic [23:0] got_out,
	output logic got_stb_out,
	output logic [7:0] turn_out
);
	logic drive = 1'b1;
	initial begin
		sclk_out = 1'b0;
		sdio_out = 1'b0;
		got_out = 24'h0;
		got_stb_out = 1'b0;
		turn_out = 8'h0;
	end
	// A released line shows a changing pattern, not the last bit
	always @(posedge clk_in) begin
		if (!drive) begin
			sdio_out <= ~sdio_out;
		end
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// Clock idles low between frames; half is never below 5 cycles
	task automatic send_bits(input int n, input logic [7:0] v, input int half);
		drive <= 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk_in);
			sdio_out <= v[i];
			wait_cyc(half);
			sclk_out <= 1'b1;
			wait_cyc(half);
			sclk_out <= 1'b0;
		end
	endtask
	// Whole read from the first bit, released line while the device talks
	task automatic read_result(input int half, input logic alt);
		int t;
		logic [23:0] v;
		send_bits(8, 8'h80, half);
		drive <= 1'b0;
		t = 0;
		while (sdio_oe_n_in !== 1'b0 && t < 40) begin
			@(posedge clk_in);
			t++;
		end
		wait_cyc(half);
		for (int i = 23; i >= 0; i--) begin
			sclk_out <= 1'b1;
			wait_cyc(half);
			v[i] = alt ? serial_result_out_in : sdio_in;
			sclk_out <= 1'b0;
			wait_cyc(half);
		end
		got_out <= v;
		turn_out <= t[7:0];
		got_stb_out <= 1'b1;
		@(posedge clk_in);
		got_stb_out <= 1'b0;
		wait_cyc(half);
		drive <= 1'b1;
		sdio_out <= 1'b0;
	endtask
	task automatic sclk_reset();
		@(posedge clk_in);
		sclk_out <= 1'b1;
		wait_cyc(600);
		sclk_out <= 1'b0;
	endtask
endmodule

// File: adc_serial_mode_sync_control_test.sv
`timescale 1ns/1ps
`include "adcs_regs.svh"
module adc_serial_mode_sync_control_test;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic mode_sel = 1'b0;
	logic sync_n = 1'b1;
	logic mod_bit = 1'b0;
	logic chan_change = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wr_data = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ready_n, sclk_dev, sclk_oe_n, sdio_dev, sdio_oe_n;
	logic ser_bit, ser_oe_n, valid, host_sclk, host_sdio, got_stb;
	logic [31:0] rd_data;
	logic [23:0] got;
	logic [7:0] turn;
	wire sclk_w = sclk_oe_n ? host_sclk : sclk_dev;
	wire sdio_w = sdio_oe_n ? host_sdio : sdio_dev;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [15:0] seed = 16'h291b;
	logic [31:0] reg_q[$];
	logic [23:0] ser_q[$];
	logic rd_seen = 1'b0;
	always #2 clk_in = ~clk_in;
	adcs_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.mode_sel_in(mode_sel), .conversion_sync_n_in(sync_n),
		.result_ready_n_out(ready_n), .sclk_in(sclk_w),
		.sclk_out(sclk_dev), .sclk_oe_n_out(sclk_oe_n), .sdio_in(sdio_w),
		.sdio_out(sdio_dev), .sdio_oe_n_out(sdio_oe_n),
		.serial_result_out(ser_bit), .serial_result_oe_n_out(ser_oe_n),
		.mod_bit_in(mod_bit), .chan_change_in(chan_change),
		.result_valid_out(valid), .addr_in(addr), .wr_data_in(wr_data),
		.wr_in(wr), .rd_in(rd), .rd_data_out(rd_data));
	adcs_host_model i_host (.clk_in(clk_in), .sdio_in(sdio_w),
		.sdio_oe_n_in(sdio_oe_n), .serial_result_out_in(ser_bit), .sclk_out(host_sclk),
		.sdio_out(host_sdio), .got_out(got), .got_stb_out(got_stb),
		.turn_out(turn));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end
	// Scoreboard side: results are matched against the oldest note
	always @(posedge clk_in) rd_seen <= rd;
	always @(negedge clk_in) begin
		if (rd_seen === 1'b1) begin
			check("rd_data", rd_data, reg_q.pop_front());
		end
		if (got_stb === 1'b1) begin
			check("serial result", {8'h0, got}, {8'h0, ser_q.pop_front()});
			check("turnaround", 32'(turn >= 8'h08 && turn <= 8'h0c), 32'h1);
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wr_data <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		reg_q.push_back(e);
		@(posedge clk_in);
		rd <= 1'b0;
	endtask
	task automatic wait_fall();
		int t;
		t = 0;
		while (ready_n !== 1'b1 && t < 2200) begin
			@(posedge clk_in);
			t++;
		end
		while (ready_n !== 1'b0 && t < 2200) begin
			@(posedge clk_in);
			t++;
		end
	endtask
	// Ones land mid-period so the count is exact
	task automatic pulse_ones(output int n);
		seed = lfsr(seed);
		n = int'(seed[6:0]) + 1;
		repeat (100) @(posedge clk_in);
		mod_bit <= 1'b1;
		repeat (n) @(posedge clk_in);
		mod_bit <= 1'b0;
	endtask
	task automatic trial(input int kind);
		int n, m, ta, tb;
		i_host.sclk_reset();
		repeat (6) @(posedge clk_in);
		check("ready_n", {31'h0, ready_n}, 32'h1);
		wait_fall();
		ta = cyc;
		pulse_ones(n);
		wait_fall();
		tb = cyc;
		reg_rd(`ADCS_REG_RESULT, 32'(n));
		if (kind == 0) begin
			check("period", 32'(tb - ta), 32'(`ADCS_CONV_CYC));
			pulse_ones(m);
			ser_q.push_back(n[23:0]);
			i_host.read_result(8, 1'b0);
			reg_rd(`ADCS_REG_STATUS, 32'h5);
			check("oe", {30'h0, sdio_oe_n, ser_oe_n}, 32'h3);
			// Second read spans the update so the new result is dropped
			while (cyc - tb < 800) @(posedge clk_in);
			ser_q.push_back(n[23:0]);
			i_host.read_result(8, 1'b0);
			reg_rd(`ADCS_REG_RESULT, 32'(n));
		end else begin
			pulse_ones(m);
			i_host.send_bits(4, 8'h0a, 8);
			repeat (140) @(posedge clk_in);
			if (kind == 1) begin
				chan_change <= 1'b1;
				@(posedge clk_in);
				chan_change <= 1'b0;
				sync_n <= 1'b0;
				repeat (4) @(posedge clk_in);
				sync_n <= 1'b1;
			end else begin
				reg_wr(`ADCS_REG_CTRL, 32'h1);
			end
			wait_fall();
			check("long period", 32'(cyc - tb > `ADCS_CONV_CYC), 32'h1);
			ser_q.push_back(n[23:0]);
			i_host.read_result(8, kind == 2);
			reg_rd(`ADCS_REG_RESULT, 32'(n));
			reg_rd(`ADCS_REG_STATUS, kind == 1 ? 32'h1 : 32'h5);
			check("valid", {31'h0, valid}, {31'h0, kind != 1});
			wait_fall();
			check("valid later", {31'h0, valid}, {31'h0, kind != 1});
			wait_fall();
			repeat (2) @(posedge clk_in);
			check("valid settled", {31'h0, valid}, 32'h1);
		end
	endtask
	task automatic master_check();
		int cnt, gap, last;
		logic prev;
		mode_sel <= 1'b1;
		wait_fall();
		cnt = 0;
		gap = 0;
		last = 0;
		prev = 1'b0;
		repeat (900) begin
			@(posedge clk_in);
			if (sclk_dev === 1'b1 && prev !== 1'b1) begin
				gap = cyc - last;
				last = cyc;
				cnt++;
			end
			prev = sclk_dev;
		end
		check("master clocks", 32'(cnt), 32'd16);
		check("master period", 32'(gap), 32'd4);
		check("sclk oe master", {31'h0, sclk_oe_n}, 32'h0);
		mode_sel <= 1'b0;
		repeat (8) @(posedge clk_in);
		check("sclk oe slave", {31'h0, sclk_oe_n}, 32'h1);
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (200) @(posedge clk_in);
		reg_rd(4'hc, 32'h0);
		for (int k = 0; k < 3; k++) begin
			trial(k);
		end
		master_check();
		final_report();
	end
endmodule
